/* File: design/prx_rx_phy.sv */
// multi-port packet receive interface, device end facing the link reader
// Notes on behaviour
// [R1] on the last word, one-byte flag high for upper-lane byte, low for two bytes
// [R2] only whole words move; only a packet's last word may be short
// [R3] start marker on the first word of every delivered packet
// [R4] end marker on the last word; start and end never together
// [R5] error flag may appear only on a packet's last word
// [R6] reader trusts the error flag only while valid is high
// [R7] errors come from overflow, abort, missing start or end, parity fault
// [R8] word flags float while the active-low read enable is high
// [R9] outputs also float for null or foreign address latched with enable high
// [R10] reader picks the fifo to read by address together with enable
// [R11] in packet mode the address also picks the polled availability fifo
// [R12] the null address 1Fh is never answered
// [R13] valid high qualifies data and flags; low means ignore them all
// [R14] valid drops when the fifo runs empty or after a packet end
// [R15] no word leaves a fifo while valid is low
// [R16] valid stays low after dropping until the port is deselected
// [R17] valid floats with enable high and for null or foreign addresses
// [R18] available when a packet end or threshold bytes are held, else low
// [R19] polled availability driven only for own address, floats otherwise
// [R20] each port has a direct availability output with the same test
// [R21] the byte threshold is set by the user
// [R22] the reader supplies the link clock between 25 and 50 MHz; the bench reader model runs it at 1.25 MHz
// [R23] data counts only with enable low and a valid port selected
// [R24] with 8-bit data the one-byte flag is absent
// [R25] polled output only in packet mode, direct outputs only in byte mode
`timescale 1ns/100ps
module prx_rx_phy #(
  parameter int DATA_W = prx_pkg::DATA_W_WIDE,
  parameter int NUM_PORTS = prx_pkg::NUM_PORTS_DEF,
  parameter int FIFO_DEPTH = prx_pkg::FIFO_DEPTH_DEF,
  parameter logic [4:0] BASE_ADDR = prx_pkg::BASE_ADDR_DEF,
  parameter bit PKT_MODE = 1'b1,
  localparam int PORT_W = (NUM_PORTS > 1) ? $clog2(NUM_PORTS) : 1
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic link_clk_in,
  input wire logic rd_en_n_in,
  input wire logic [prx_pkg::ADDR_W-1:0] rd_addr_in,
  output logic [DATA_W-1:0] rx_data_out,
  output logic rx_data_oe_out,
  output logic rx_par_out,
  output logic rx_par_oe_out,
  output logic rx_start_out,
  output logic rx_start_oe_out,
  output logic rx_end_out,
  output logic rx_end_oe_out,
  output logic rx_one_byte_out,
  output logic rx_one_byte_oe_out,
  output logic rx_err_out,
  output logic rx_err_oe_out,
  output logic rx_valid_out,
  output logic rx_valid_oe_out,
  output logic poll_avail_out,
  output logic poll_avail_oe_out,
  output logic [NUM_PORTS-1:0] port_avail_out,
  input wire logic [prx_pkg::THRESH_W-1:0] thresh_bytes_in,
  input wire logic parity_odd_in,
  input wire logic wr_valid_in,
  input wire logic [PORT_W-1:0] wr_port_in,
  input wire logic [DATA_W-1:0] wr_data_in,
  input wire logic wr_sop_in,
  input wire logic wr_eop_in,
  input wire logic wr_one_byte_in,
  input wire logic wr_abort_in,
  input wire logic wr_par_err_in,
  input wire logic wr_ovf_in,
  output logic [NUM_PORTS-1:0] wr_ready_out
);
  localparam int CNT_W = $clog2(FIFO_DEPTH + 1);
  localparam int SYNC_W = prx_pkg::ADDR_W + 2;

  if (DATA_W != prx_pkg::DATA_W_WIDE && DATA_W != prx_pkg::DATA_W_NARROW) begin : g_chk_w
    $error("data width must be 8 or 16");
  end
  if (NUM_PORTS < 1 || int'(BASE_ADDR) + NUM_PORTS > int'(prx_pkg::NULL_ADDR)) begin : g_chk_p
    $error("port addresses must lie below the null address");
  end
  if (FIFO_DEPTH <= prx_pkg::READY_MARGIN + 1) begin : g_chk_d
    $error("fifo depth too small for the ready margin");
  end
  if (prx_pkg::SYNC_STAGES != 3) begin : g_chk_s
    $error("the pin synchroniser is built with three stages");
  end

  // link-side inputs, synchronised
  logic [SYNC_W-1:0] link_sync;
  logic link_lvl;
  logic link_prev;
  logic link_rise;
  logic en_n_s;
  logic [prx_pkg::ADDR_W-1:0] addr_s;

  // enable and address pass inverted, so a flushed synchroniser reads as
  // deselected on the null address rather than port zero selected
  prx_sync #(.W(SYNC_W)) u_sync (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .d_in({link_clk_in, ~rd_en_n_in, ~rd_addr_in}),
    .q_out(link_sync)
  );

  assign link_lvl = link_sync[SYNC_W-1];
  assign en_n_s = ~link_sync[SYNC_W-2];
  assign addr_s = ~link_sync[prx_pkg::ADDR_W-1:0];
  assign link_rise = link_lvl & ~link_prev;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      link_prev <= 1'b0;
    end else begin
      link_prev <= link_lvl;
    end
  end

  // own port addresses exclude the null address
  function automatic logic addr_ok(input logic [prx_pkg::ADDR_W-1:0] a);
    addr_ok = (a != prx_pkg::NULL_ADDR) && (a >= BASE_ADDR) &&   // [R12]
              ({1'b0, a} < 6'(int'(BASE_ADDR) + NUM_PORTS));
  endfunction : addr_ok

  function automatic logic [PORT_W-1:0] addr_idx(input logic [prx_pkg::ADDR_W-1:0] a);
    logic [prx_pkg::ADDR_W-1:0] d;
    d = a - BASE_ADDR;
    addr_idx = d[PORT_W-1:0];
  endfunction : addr_idx

  // per-port fifo views
  logic [DATA_W-1:0] head_data [NUM_PORTS];
  logic [NUM_PORTS-1:0] head_sop;
  logic [NUM_PORTS-1:0] head_eop;
  logic [NUM_PORTS-1:0] head_mod;
  logic [NUM_PORTS-1:0] head_err;
  logic [NUM_PORTS-1:0] fifo_empty;
  logic [NUM_PORTS-1:0] avail;
  logic [NUM_PORTS-1:0] pop_sel;
  logic [CNT_W-1:0] fill [NUM_PORTS];

  for (genvar i = 0; i < NUM_PORTS; i++) begin : g_port
    prx_fifo_if #(.DATA_W(DATA_W), .CNT_W(CNT_W)) fif ();
    logic hit;
    logic in_pkt;
    logic pend_err;
    logic cause;
    logic next_push;
    logic next_sop;
    logic next_eop;
    logic next_err;
    logic next_in_pkt;
    logic next_pend;
    logic [prx_pkg::THRESH_W-1:0] fill_bytes;

    prx_pkt_fifo #(.DATA_W(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .fifo(fif.store)
    );

    assign hit = wr_valid_in && (wr_port_in == PORT_W'(i)) && wr_ready_out[i];
    assign cause = wr_abort_in | wr_par_err_in | wr_ovf_in;   // [R7]

    // framing repair: every stored packet has one start and one end
    always_comb begin
      next_push = 1'b0;
      next_sop = 1'b0;
      next_eop = 1'b0;
      next_err = 1'b0;
      next_in_pkt = in_pkt;
      next_pend = pend_err;
      if (hit) begin
        if (wr_sop_in && in_pkt) begin
          // missing end: this word closes the old packet as aborted
          next_push = 1'b1;
          next_eop = 1'b1;   // [R4]
          next_err = 1'b1;   // [R7]
          next_in_pkt = 1'b0;
          next_pend = 1'b0;
        end else if (!in_pkt && wr_eop_in) begin
          // an end word outside a packet, with or without start, cannot be framed, dropped
          next_pend = 1'b0;   // [R4]
        end else begin
          next_push = 1'b1;
          next_sop = !in_pkt;   // [R3]
          next_eop = wr_eop_in;
          next_err = wr_eop_in & (pend_err | cause);   // [R5]
          next_in_pkt = !wr_eop_in;
          next_pend = !wr_eop_in & (pend_err | cause | (!in_pkt & !wr_sop_in));   // [R7]
        end
      end
    end

    always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
        in_pkt <= 1'b0;
        pend_err <= 1'b0;
      end else begin
        in_pkt <= next_in_pkt;
        pend_err <= next_pend;
      end
    end

    assign fif.push = next_push;
    assign fif.wdata = wr_data_in;   // [R2]
    assign fif.wsop = next_sop;
    assign fif.weop = next_eop;
    assign fif.wmod = next_eop & wr_one_byte_in & (DATA_W == prx_pkg::DATA_W_WIDE);   // [R1]
    assign fif.werr = next_err;
    assign fif.pop = pop_sel[i];

    assign head_data[i] = fif.rdata;
    assign head_sop[i] = fif.rsop;
    assign head_eop[i] = fif.reop;
    assign head_mod[i] = fif.rmod;
    assign head_err[i] = fif.rerr;
    assign fifo_empty[i] = fif.empty;
    assign fill[i] = fif.level;

    assign fill_bytes = (DATA_W == prx_pkg::DATA_W_WIDE) ?
                        prx_pkg::THRESH_W'({fif.level, 1'b0}) :
                        prx_pkg::THRESH_W'(fif.level);
    assign avail[i] = (fif.eop_cnt != '0) || (fill_bytes >= thresh_bytes_in);   // [R18] [R21]

    // write back-pressure leaves room for one push after ready falls
    always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
        wr_ready_out[i] <= 1'b0;
      end else begin
        wr_ready_out[i] <= fill[i] < CNT_W'(FIFO_DEPTH - prx_pkg::READY_MARGIN);
      end
    end

    always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
        port_avail_out[i] <= 1'b0;
      end else begin
        port_avail_out[i] <= !PKT_MODE && avail[i];   // [R20] [R25]
      end
    end
  end

  // read side, advanced once per link clock rising edge
  prx_pkg::prx_rd_state_t rd_state;
  logic [prx_pkg::ADDR_W-1:0] sel_addr;
  logic [PORT_W-1:0] sel_idx;
  logic sel_ok;
  logic take;

  assign sel_idx = addr_idx(sel_addr);
  assign sel_ok = addr_ok(sel_addr);   // [R9] [R12]
  assign take = link_rise && !en_n_s && sel_ok && (rd_state != prx_pkg::PRX_RD_HELD) &&
                !fifo_empty[sel_idx];   // [R23]

  for (genvar j = 0; j < NUM_PORTS; j++) begin : g_pop
    assign pop_sel[j] = take && (sel_idx == PORT_W'(j));   // [R15]
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rd_state <= prx_pkg::PRX_RD_DESEL;
      sel_addr <= prx_pkg::NULL_ADDR;
    end else if (link_rise) begin
      if (en_n_s) begin
        rd_state <= prx_pkg::PRX_RD_DESEL;   // [R16]
        sel_addr <= addr_s;   // [R10]
      end else if (sel_ok) begin
        case (rd_state)
          prx_pkg::PRX_RD_DESEL, prx_pkg::PRX_RD_STREAM: begin
            if (fifo_empty[sel_idx] || head_eop[sel_idx]) begin
              rd_state <= prx_pkg::PRX_RD_HELD;   // [R14]
            end else begin
              rd_state <= prx_pkg::PRX_RD_STREAM;
            end
          end
          prx_pkg::PRX_RD_HELD: begin
            rd_state <= prx_pkg::PRX_RD_HELD;   // [R16]
          end
          default: begin
            rd_state <= prx_pkg::PRX_RD_DESEL;
          end
        endcase
      end
    end
  end

  // word and flag registers
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rx_data_out <= '0;
      rx_par_out <= 1'b0;
      rx_start_out <= 1'b0;
      rx_end_out <= 1'b0;
      rx_one_byte_out <= 1'b0;
      rx_err_out <= 1'b0;
      rx_valid_out <= 1'b0;
    end else if (link_rise) begin
      rx_valid_out <= take;   // [R13] [R14]
      rx_start_out <= take & head_sop[sel_idx];   // [R3]
      rx_end_out <= take & head_eop[sel_idx];   // [R4]
      rx_one_byte_out <= take & head_mod[sel_idx];   // [R1] [R24]
      rx_err_out <= take & head_err[sel_idx];   // [R5]
      if (take) begin
        rx_data_out <= head_data[sel_idx];
        rx_par_out <= (^head_data[sel_idx]) ^ parity_odd_in;
      end
    end
  end

  // output enables follow enable and the latched address
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rx_data_oe_out <= 1'b0;
      rx_par_oe_out <= 1'b0;
      rx_start_oe_out <= 1'b0;
      rx_end_oe_out <= 1'b0;
      rx_one_byte_oe_out <= 1'b0;
      rx_err_oe_out <= 1'b0;
      rx_valid_oe_out <= 1'b0;
    end else if (link_rise) begin
      rx_data_oe_out <= !en_n_s && sel_ok;   // [R8] [R9]
      rx_par_oe_out <= !en_n_s && sel_ok;
      rx_start_oe_out <= !en_n_s && sel_ok;
      rx_end_oe_out <= !en_n_s && sel_ok;
      rx_one_byte_oe_out <= !en_n_s && sel_ok && (DATA_W == prx_pkg::DATA_W_WIDE);   // [R24]
      rx_err_oe_out <= !en_n_s && sel_ok;
      rx_valid_oe_out <= !en_n_s && sel_ok;   // [R17]
    end
  end

  // polled availability follows the address on every link clock rising edge
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      poll_avail_out <= 1'b0;
      poll_avail_oe_out <= 1'b0;
    end else if (link_rise) begin
      poll_avail_oe_out <= PKT_MODE && addr_ok(addr_s);   // [R19] [R25]
      poll_avail_out <= PKT_MODE && addr_ok(addr_s) && avail[addr_idx(addr_s)];   // [R11] [R18]
    end
  end
endmodule : prx_rx_phy

/* File: design/prx_pkg.sv */
// shared constants and types of the packet receive port block
package prx_pkg;
  localparam int ADDR_W = 5;
  localparam logic [4:0] NULL_ADDR = 5'h1F;
  localparam int DATA_W_WIDE = 16;
  localparam int DATA_W_NARROW = 8;
  localparam int NUM_PORTS_DEF = 4;
  localparam int FIFO_DEPTH_DEF = 16;
  localparam int THRESH_W = 16;
  localparam int SYNC_STAGES = 3;
  localparam int READY_MARGIN = 2;
  localparam logic [4:0] BASE_ADDR_DEF = 5'h00;
  // entry layout above the data bits
  localparam int ENT_SOP = 0;
  localparam int ENT_EOP = 1;
  localparam int ENT_MOD = 2;
  localparam int ENT_ERR = 3;
  localparam int ENT_FLAGS = 4;
  typedef enum logic [1:0] {PRX_RD_DESEL, PRX_RD_STREAM, PRX_RD_HELD} prx_rd_state_t;
endpackage : prx_pkg

/* File: design/prx_fifo_if.sv */
// carrier between the port logic and one packet fifo
`timescale 1ns/100ps
interface prx_fifo_if #(parameter int DATA_W = 16, parameter int CNT_W = 5);
  logic push;
  logic pop;
  logic [DATA_W-1:0] wdata;
  logic wsop;
  logic weop;
  logic wmod;
  logic werr;
  logic [DATA_W-1:0] rdata;
  logic rsop;
  logic reop;
  logic rmod;
  logic rerr;
  logic empty;
  logic [CNT_W-1:0] level;
  logic [CNT_W-1:0] eop_cnt;
  modport store (input push, pop, wdata, wsop, weop, wmod, werr,
                 output rdata, rsop, reop, rmod, rerr, empty, level, eop_cnt);
  modport user (output push, pop, wdata, wsop, weop, wmod, werr,
                input rdata, rsop, reop, rmod, rerr, empty, level, eop_cnt);
endinterface : prx_fifo_if

/* File: design/prx_sync.sv */
// three-stage synchroniser; a bit changes once stages two and three agree
`timescale 1ns/100ps
module prx_sync #(parameter int W = 1) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= d_in;
      s2 <= s1;
      s3 <= s2;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      q_out <= '0;
    end else begin
      q_out <= (s2 & ~(s2 ^ s3)) | (q_out & (s2 ^ s3));
    end
  end
endmodule : prx_sync

/* File: design/prx_pkt_fifo.sv */
// per-port packet word fifo with fill and packet-end counts
`timescale 1ns/100ps
module prx_pkt_fifo #(parameter int DATA_W = 16, parameter int DEPTH = 16) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  prx_fifo_if.store fifo
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam int ENT_W = DATA_W + prx_pkg::ENT_FLAGS;

  logic [ENT_W-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] eops;
  logic [ENT_W-1:0] head;
  logic do_push;
  logic do_pop;

  if (DEPTH < 4 || (1 << PTR_W) != DEPTH) begin : g_chk
    $error("fifo depth must be a power of two of at least 4");
  end

  assign do_push = fifo.push && (count != CNT_W'(DEPTH));
  assign do_pop = fifo.pop && (count != '0);
  assign head = mem[rd_ptr];

  always_ff @(posedge clk_in) begin
    if (do_push) begin
      mem[wr_ptr] <= {fifo.werr, fifo.wmod, fifo.weop, fifo.wsop, fifo.wdata};
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= wr_ptr + PTR_W'(do_push);
      rd_ptr <= rd_ptr + PTR_W'(do_pop);
      count <= count + CNT_W'(do_push) - CNT_W'(do_pop);
    end
  end

  // count of whole packets held, so availability sees any stored end
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      eops <= '0;
    end else begin
      eops <= eops + CNT_W'(do_push && fifo.weop)
                   - CNT_W'(do_pop && head[DATA_W + prx_pkg::ENT_EOP]);
    end
  end

  assign fifo.rdata = head[DATA_W-1:0];
  assign fifo.rsop = head[DATA_W + prx_pkg::ENT_SOP];
  assign fifo.reop = head[DATA_W + prx_pkg::ENT_EOP];
  assign fifo.rmod = head[DATA_W + prx_pkg::ENT_MOD];
  assign fifo.rerr = head[DATA_W + prx_pkg::ENT_ERR];
  assign fifo.empty = (count == '0);
  assign fifo.level = count;
  assign fifo.eop_cnt = eops;
endmodule : prx_pkt_fifo

/* File: verif/prx_rx_phy_monitor.sv */
// assertion checker for the packet receive port block
`timescale 1ns/100ps
module prx_rx_phy_monitor #(
  parameter int DATA_W = 16,
  parameter bit PKT_MODE = 1'b1,
  parameter int NUM_PORTS = 4
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic rd_en_n_in,
  input wire logic [prx_pkg::ADDR_W-1:0] rd_addr_in,
  input wire logic parity_odd_in,
  input wire logic [DATA_W-1:0] rx_data_out,
  input wire logic rx_data_oe_out,
  input wire logic rx_par_out,
  input wire logic rx_par_oe_out,
  input wire logic rx_start_out,
  input wire logic rx_start_oe_out,
  input wire logic rx_end_out,
  input wire logic rx_end_oe_out,
  input wire logic rx_one_byte_out,
  input wire logic rx_one_byte_oe_out,
  input wire logic rx_err_out,
  input wire logic rx_err_oe_out,
  input wire logic rx_valid_out,
  input wire logic rx_valid_oe_out,
  input wire logic poll_avail_oe_out,
  input wire logic [NUM_PORTS-1:0] port_avail_out
);
  logic [4:0] en_hi_cnt;
  logic [4:0] null_cnt;
  logic held;
  default clocking mon_cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || !rd_en_n_in) begin
      en_hi_cnt <= 5'h00;
    end else if (en_hi_cnt != 5'h1F) begin
      en_hi_cnt <= en_hi_cnt + 5'h01;
    end
  end
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || rd_addr_in != prx_pkg::NULL_ADDR) begin
      null_cnt <= 5'h00;
    end else if (null_cnt != 5'h1F) begin
      null_cnt <= null_cnt + 5'h01;
    end
  end
  // set once valid fell while the port stayed selected
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || rd_en_n_in) begin
      held <= 1'b0;
    end else if (rx_valid_oe_out && $past(rx_valid_out) && !rx_valid_out) begin
      held <= 1'b1;
    end
  end
  sequence end_word_s;
    rx_valid_out && rx_end_out;
  endsequence
  sequence end_gone_s;
    !rx_end_out;
  endsequence
  end_drop_a: assert property (end_word_s ##1 end_gone_s |-> !rx_valid_out)
    else $error("valid still high after the end word");
  start_end_a: assert property (rx_valid_out |-> !(rx_start_out && rx_end_out))
    else $error("start and end together");
  err_on_end_a: assert property (rx_err_out |-> rx_end_out && rx_valid_out)
    else $error("error flag away from the end word");
  one_byte_end_a: assert property (rx_one_byte_out |-> rx_end_out)
    else $error("one byte flag away from the end word");
  flags_float_a: assert property (en_hi_cnt == 5'h18 |-> !(rx_start_oe_out || rx_end_oe_out ||
    rx_one_byte_oe_out || rx_err_oe_out || rx_valid_oe_out || rx_data_oe_out || rx_par_oe_out))
    else $error("receive outputs driven with enable high");
  null_float_a: assert property (null_cnt == 5'h18 |-> !poll_avail_oe_out)
    else $error("poll output driven for the null address");
  valid_held_a: assert property (held |-> !rx_valid_out)
    else $error("valid rose again without deselect");
  parity_ok_a: assert property (rx_valid_out && rx_par_oe_out |->
    rx_par_out == ((^rx_data_out) ^ parity_odd_in))
    else $error("parity does not match data");
  direct_quiet_a: assert property (PKT_MODE |-> port_avail_out == '0)
    else $error("direct availability active in packet mode");
endmodule : prx_rx_phy_monitor

bind prx_rx_phy prx_rx_phy_monitor #(.DATA_W(DATA_W), .PKT_MODE(PKT_MODE), .NUM_PORTS(NUM_PORTS))
  i_mon (.clk_in(clk_in), .rst_n_in(rst_n_in), .rd_en_n_in(rd_en_n_in), .rd_addr_in(rd_addr_in),
  .parity_odd_in(parity_odd_in), .rx_data_out(rx_data_out), .rx_data_oe_out(rx_data_oe_out),
  .rx_par_out(rx_par_out), .rx_par_oe_out(rx_par_oe_out), .rx_start_out(rx_start_out),
  .rx_start_oe_out(rx_start_oe_out), .rx_end_out(rx_end_out), .rx_end_oe_out(rx_end_oe_out),
  .rx_one_byte_out(rx_one_byte_out), .rx_one_byte_oe_out(rx_one_byte_oe_out),
  .rx_err_out(rx_err_out), .rx_err_oe_out(rx_err_oe_out), .rx_valid_out(rx_valid_out),
  .rx_valid_oe_out(rx_valid_oe_out), .poll_avail_oe_out(poll_avail_oe_out),
  .port_avail_out(port_avail_out));

/* File: verif/prx_link_reader.sv */
// link reader model: receive clock, port select and word capture
`timescale 1ns/100ps
module prx_link_reader #(parameter int DATA_W = 16) (
  output logic link_clk_out,
  output logic rd_en_n_out,
  output logic [4:0] rd_addr_out,
  input wire logic [DATA_W-1:0] rx_data_in,
  input wire logic rx_valid_in,
  input wire logic rx_valid_oe_in,
  input wire logic rx_start_in,
  input wire logic rx_end_in,
  input wire logic rx_one_byte_in,
  input wire logic rx_err_in
);
  logic [DATA_W-1:0] got_data[$];
  logic [3:0] got_flags[$];
  // receive clock runs free, as the reader supplies it
  initial begin
    link_clk_out = 1'b0;
    rd_en_n_out = 1'b1;
    rd_addr_out = 5'h1F;
    forever #400 link_clk_out = ~link_clk_out;
  end
  always @(posedge link_clk_out) begin
    if (rx_valid_oe_in === 1'b1 && rx_valid_in === 1'b1 && !rd_en_n_out) begin
      got_data.push_back(rx_data_in);
      got_flags.push_back({rx_start_in, rx_end_in, rx_one_byte_in, rx_err_in});
    end
  end
  // address with enable high, then enable low when go is set
  task automatic select_port(input logic [4:0] addr, input logic go);
    @(posedge link_clk_out);
    #10;
    rd_en_n_out = 1'b1;
    rd_addr_out = addr;
    repeat (2) @(posedge link_clk_out);
    #10;
    rd_en_n_out = !go;
  endtask : select_port
  task automatic release_port();
    @(posedge link_clk_out);
    #10;
    rd_en_n_out = 1'b1;
  endtask : release_port
endmodule : prx_link_reader

/* File: verif/prx_rx_phy_bench.sv */
// self-checking bench of the packet receive port block
`timescale 1ns/100ps
module prx_rx_phy_bench;
  logic clk_in, rst_n_in, link_clk, rd_en_n, parity_odd, wr_valid;
  logic wr_sop, wr_eop, wr_ob, wr_abort, wr_par_err, wr_ovf;
  logic [4:0] rd_addr;
  logic [1:0] wr_port;
  logic [15:0] wr_data, thresh, rx_data;
  logic rx_valid, rx_valid_oe, rx_start, rx_start_oe, rx_end, rx_end_oe, rx_data_oe;
  logic rx_ob, rx_err, rx_err_oe, poll_avail, poll_avail_oe;
  logic [3:0] port_avail, wr_ready;
  int bad_count = 0;
  int total_checks = 0;
  prx_rx_phy #(.PKT_MODE(1'b1)) i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .link_clk_in(link_clk), .rd_en_n_in(rd_en_n), .rd_addr_in(rd_addr), .rx_data_out(rx_data),
    .rx_data_oe_out(rx_data_oe), .rx_par_out(), .rx_par_oe_out(), .rx_start_out(rx_start),
    .rx_start_oe_out(rx_start_oe), .rx_end_out(rx_end), .rx_end_oe_out(rx_end_oe),
    .rx_one_byte_out(rx_ob), .rx_one_byte_oe_out(), .rx_err_out(rx_err),
    .rx_err_oe_out(rx_err_oe), .rx_valid_out(rx_valid), .rx_valid_oe_out(rx_valid_oe),
    .poll_avail_out(poll_avail), .poll_avail_oe_out(poll_avail_oe), .port_avail_out(port_avail),
    .thresh_bytes_in(thresh), .parity_odd_in(parity_odd), .wr_valid_in(wr_valid),
    .wr_port_in(wr_port), .wr_data_in(wr_data), .wr_sop_in(wr_sop), .wr_eop_in(wr_eop),
    .wr_one_byte_in(wr_ob), .wr_abort_in(wr_abort), .wr_par_err_in(wr_par_err),
    .wr_ovf_in(wr_ovf), .wr_ready_out(wr_ready));
  prx_link_reader #(.DATA_W(16)) i_reader (.link_clk_out(link_clk), .rd_en_n_out(rd_en_n),
    .rd_addr_out(rd_addr), .rx_data_in(rx_data), .rx_valid_in(rx_valid),
    .rx_valid_oe_in(rx_valid_oe), .rx_start_in(rx_start), .rx_end_in(rx_end),
    .rx_one_byte_in(rx_ob), .rx_err_in(rx_err));
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  function automatic logic [15:0] wv(input logic [1:0] p, input int i);
    return {6'h00, p, 4'hA, 4'(i)};
  endfunction : wv
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // flags: start, end, one byte, abort, parity fault, overflow
  task automatic put(input logic [1:0] p, input logic [15:0] d, input logic [5:0] f);
    int n;
    wr_valid = 1'b1;
    wr_port = p;
    wr_data = d;
    {wr_sop, wr_eop, wr_ob, wr_abort, wr_par_err, wr_ovf} = f;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (wr_ready[p] !== 1'b1 && n < 50);
    if (wr_ready[p] !== 1'b1) bad_count++;
    #10;
  endtask : put
  task automatic check_pkt(input logic [1:0] p, input int n, input logic ob, input logic err);
    i_reader.got_data.delete();
    i_reader.got_flags.delete();
    i_reader.select_port({3'h0, p}, 1'b1);
    repeat (n + 4) @(posedge link_clk);
    i_reader.release_port();
    check(16'(i_reader.got_data.size()), 16'(n));
    for (int i = 0; i < n && i < i_reader.got_data.size(); i++) begin
      check(i_reader.got_data[i], wv(p, i));
      check({12'h000, i_reader.got_flags[i]},
        {12'h000, i == 0, i == n - 1, ob && i == n - 1, err && i == n - 1});
    end
  endtask : check_pkt
  task automatic sc_frame();
    thresh = 16'h0040;
    for (int i = 0; i < 3; i++) put(2'h1, wv(2'h1, i), {i == 0, i == 2, i == 2, 3'h0});
    wr_valid = 1'b0;
    i_reader.select_port(5'h01, 1'b0);
    check({14'h0000, poll_avail_oe, poll_avail}, 16'h0003);
    check({12'h000, port_avail}, 16'h0000);
    check_pkt(2'h1, 3, 1'b1, 1'b0);
    i_reader.select_port(5'h01, 1'b0);
    check({14'h0000, poll_avail_oe, poll_avail}, 16'h0002);
  endtask : sc_frame
  task automatic sc_errors();
    for (int c = 0; c < 5; c++) begin
      put(2'h2, wv(2'h2, 0), {c != 3, 2'b00, c == 0, c == 1, c == 2});
      put(2'h2, wv(2'h2, 1), {c == 4, c != 4, 4'h0});
      wr_valid = 1'b0;
      check_pkt(2'h2, 2, 1'b0, 1'b1);
    end
  endtask : sc_errors
  task automatic sc_hold();
    for (int k = 0; k < 4; k++) put(2'h3, wv(2'h3, k % 2), {k % 2 == 0, k % 2 == 1, 4'h0});
    wr_valid = 1'b0;
    check_pkt(2'h3, 2, 1'b0, 1'b0);
    check_pkt(2'h3, 2, 1'b0, 1'b0);
  endtask : sc_hold
  task automatic sc_float();
    thresh = 16'h0004;
    put(2'h0, wv(2'h0, 0), 6'b100000);
    wr_valid = 1'b0;
    i_reader.select_port(5'h00, 1'b0);
    check({14'h0000, poll_avail_oe, poll_avail}, 16'h0002);
    put(2'h0, wv(2'h0, 1), 6'b000000);
    wr_valid = 1'b0;
    i_reader.select_port(5'h00, 1'b0);
    check({14'h0000, poll_avail_oe, poll_avail}, 16'h0003);
    for (int a = 0; a < 2; a++) begin
      i_reader.select_port(a == 0 ? 5'h04 : prx_pkg::NULL_ADDR, 1'b1);
      repeat (3) @(posedge link_clk);
      check({12'h000, rx_valid_oe, rx_start_oe, rx_data_oe, poll_avail_oe}, 16'h0000);
      i_reader.release_port();
    end
    repeat (3) @(posedge link_clk);
    check({12'h000, rx_valid_oe, rx_end_oe, rx_err_oe, rx_start_oe}, 16'h0000);
    put(2'h0, wv(2'h0, 2), 6'b011000);
    wr_valid = 1'b0;
    parity_odd = 1'b0;
    check_pkt(2'h0, 3, 1'b1, 1'b0);
  endtask : sc_float
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude
  initial begin
    rst_n_in = 1'b0;
    thresh = 16'h0000;
    parity_odd = 1'b1;
    wr_valid = 1'b0;
    wr_port = 2'h0;
    wr_data = 16'h0000;
    {wr_sop, wr_eop, wr_ob, wr_abort, wr_par_err, wr_ovf} = 6'h00;
    repeat (8) @(posedge clk_in);
    #10;
    rst_n_in = 1'b1;
    repeat (4) @(posedge clk_in);
    #10;
    sc_frame();
    sc_errors();
    sc_hold();
    sc_float();
    conclude();
  end
  // whole sequence needs about 100 us
  initial begin
    #2000000;
    bad_count++;
    conclude();
  end
endmodule : prx_rx_phy_bench
